// ### rtl/fpc_top.sv
// Pin control, reset handling and write protection of the flash device.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module fpc_top
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_start_input_n,
  input  wire logic        rst_pin_n,
  input  wire logic        init_pin_n,
  input  wire logic        boot_sector_lock_input,
  input  wire logic        write_protect_input,
  input  wire logic [3:0]  strap_select_inputs,
  input  wire logic [4:0]  general_purpose_inputs,
  input  wire logic        port_select_input,
  input  wire logic        row_col_strobe,
  input  wire logic [3:0]  lad_in,
  output logic      [3:0]  lad_out,
  output logic      [3:0]  lad_oe,
  output logic             done_indicator,
  output logic             cycle_active,
  output logic             is_boot_device,
  output logic             auto_start,
  output logic      [18:0] mux_addr
);
  fpc_pin_if pins();

  fpc_sync u_sync
  (
    .mclk                   (mclk),
    .srst                   (srst),
    .frame_start_input_n    (frame_start_input_n),
    .rst_pin_n              (rst_pin_n),
    .init_pin_n             (init_pin_n),
    .boot_sector_lock_input (boot_sector_lock_input),
    .write_protect_input    (write_protect_input),
    .strap_select_inputs    (strap_select_inputs),
    .general_purpose_inputs (general_purpose_inputs),
    .port_select_input      (port_select_input),
    .row_col_strobe         (row_col_strobe),
    .lad_in                 (lad_in),
    .pins                   (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    fpc_pkg::fpc_bus_t  bus;
    fpc_pkg::fpc_auto_t auto_st;
    logic [7:0]  busy_cnt;
    logic        mux_mode;
    logic        in_reset;
    logic        frame_q;
    logic        rc_q;
    logic        array_read;
    logic        refused;
    logic        erase;
    logic [18:0] target;
    logic [10:0] lock;
    logic [18:0] maddr;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        start;
    logic        done;
    logic        boot_id;
    logic [3:0]  oe;
    logic        cyc;
  } fpc_state_t;

  fpc_state_t st_reg;
  fpc_state_t st_next;

  function automatic logic [3:0] sector_of(input logic [18:0] a);
    if (a[18:16] != 3'h0)
      sector_of = {1'b0, a[18:16]} + 4'h3;
    else if (a[15])
      sector_of = 4'h3;
    else if (a[14])
      sector_of = 4'h2;
    else
      sector_of = {3'h0, a[13]};
  endfunction

  logic        dev_reset;
  logic        apb_acc;
  logic        apb_wr;
  logic [3:0]  tsect;
  logic        hw_block;
  logic        sw_block;

  always_comb
  begin
    // Initialise input only resets in bus mode; in mux mode it is output enable.
    dev_reset = !pins.rst_n || (!st_reg.mux_mode && !pins.init_n);
    apb_acc   = psel && penable && !st_reg.ready;
    // Writes take effect at the edge where the master sees pready high.
    apb_wr    = psel && penable && st_reg.ready && pwrite;
    tsect     = sector_of(st_reg.target);
    hw_block  = (tsect == fpc_pkg::TOP_SECTOR) ? !pins.boot_lock : !pins.wp;
    sw_block  = st_reg.lock[tsect];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next         = st_reg;
    st_next.ready   = apb_acc;
    st_next.slverr  = 1'b0;
    st_next.start   = 1'b0;
    st_next.frame_q = pins.frame_n;
    st_next.rc_q    = pins.rc;
    st_next.in_reset = dev_reset;
    if (st_reg.in_reset && !dev_reset)
    begin
      st_next.mux_mode   = pins.port_sel;
      st_next.boot_id    = (pins.strap == fpc_pkg::BOOT_STRAP);
      st_next.array_read = 1'b1;
    end
    if (!st_reg.mux_mode)
    begin
      if (!pins.frame_n && st_reg.frame_q)
        st_next.bus = fpc_pkg::FPC_BUS_CYCLE;
      else if (!pins.frame_n && st_reg.bus == fpc_pkg::FPC_BUS_CYCLE)
        st_next.bus = fpc_pkg::FPC_BUS_CYCLE;
    end
    else
    begin
      if (!pins.rc && st_reg.rc_q)
        st_next.maddr[10:0] = {pins.gpi, pins.wp, pins.boot_lock, pins.strap};
      if (pins.rc && !st_reg.rc_q)
        st_next.maddr[18:11] = {pins.gpi[1:0], pins.wp, pins.boot_lock, pins.strap[3:0]};
    end
    st_next.oe = (!st_reg.mux_mode && st_reg.bus == fpc_pkg::FPC_BUS_CYCLE && !pins.frame_n) ? 4'h0 :
                 (st_reg.mux_mode && !pins.init_n) ? 4'hF : 4'h0;
    if (apb_wr)
    begin
      case (paddr)
        fpc_pkg::ADDR_LOCK:    st_next.lock = pwdata[10:0];
        fpc_pkg::ADDR_REQ:     st_next.target = pwdata[18:0];
        fpc_pkg::ADDR_CTRL:
        begin
          st_next.erase = pwdata[fpc_pkg::CTL_ERASE_BIT];
          if (pwdata[fpc_pkg::CTL_REQ_BIT] && st_reg.auto_st == fpc_pkg::FPC_AUTO_IDLE)
          begin
            if (hw_block || sw_block || dev_reset)
              st_next.refused = 1'b1;
            else
            begin
              st_next.refused    = 1'b0;
              st_next.auto_st    = fpc_pkg::FPC_AUTO_BUSY;
              st_next.busy_cnt   = fpc_pkg::BUSY_CYCLES;
              st_next.start      = 1'b1;
              st_next.array_read = 1'b0;
            end
          end
        end
        default:               st_next.slverr = 1'b0;
      endcase
    end
    if (apb_acc)
    begin
      if (pwrite)
      begin
        case (paddr)
          fpc_pkg::ADDR_CTRL,
          fpc_pkg::ADDR_LOCK,
          fpc_pkg::ADDR_REQ,
          fpc_pkg::ADDR_STATUS,
          fpc_pkg::ADDR_GPI,
          fpc_pkg::ADDR_MUXADDR: st_next.slverr = 1'b0;
          default:               st_next.slverr = 1'b1;
        endcase
      end
      else
      begin
        case (paddr)
          fpc_pkg::ADDR_CTRL:    st_next.rdata = {31'h0, st_reg.erase};
          fpc_pkg::ADDR_LOCK:    st_next.rdata = {21'h0, st_reg.lock};
          fpc_pkg::ADDR_STATUS:  st_next.rdata = {24'h0, st_reg.auto_st == fpc_pkg::FPC_AUTO_IDLE,
                                                 st_reg.refused, st_reg.array_read, st_reg.mux_mode,
                                                 st_reg.boot_id, 1'b0, st_reg.bus == fpc_pkg::FPC_BUS_CYCLE,
                                                 1'b0};
          fpc_pkg::ADDR_GPI:     st_next.rdata = {23'h0, pins.strap, pins.gpi};
          fpc_pkg::ADDR_REQ:     st_next.rdata = {13'h0, st_reg.target};
          fpc_pkg::ADDR_MUXADDR: st_next.rdata = {13'h0, st_reg.maddr};
          default:
          begin
            st_next.rdata  = 32'h0000_0000;
            st_next.slverr = 1'b1;
          end
        endcase
      end
    end
    if (st_reg.auto_st == fpc_pkg::FPC_AUTO_BUSY)
    begin
      if (st_reg.busy_cnt == 8'h00)
      begin
        st_next.auto_st    = fpc_pkg::FPC_AUTO_IDLE;
        st_next.array_read = 1'b1;
      end
      else
        st_next.busy_cnt = st_reg.busy_cnt - 8'h01;
    end
    if (dev_reset)
    begin
      st_next.bus      = fpc_pkg::FPC_BUS_IDLE;
      st_next.auto_st  = fpc_pkg::FPC_AUTO_IDLE;
      st_next.busy_cnt = 8'h00;
      st_next.start    = 1'b0;
      st_next.oe       = 4'h0;
    end
    st_next.done = (st_next.auto_st == fpc_pkg::FPC_AUTO_IDLE);
    st_next.cyc  = (st_next.bus == fpc_pkg::FPC_BUS_CYCLE);
    if (srst)
    begin
      st_next            = '0;
      st_next.in_reset   = 1'b1;
      st_next.frame_q    = 1'b1;
      st_next.rc_q       = 1'b1;
      st_next.array_read = 1'b1;
      st_next.done       = 1'b1;
      st_next.lock       = fpc_pkg::LOCK_RST;
    end
  end

  always_ff @(posedge mclk)
  begin
    st_reg <= st_next;
  end

  assign prdata         = st_reg.rdata;
  assign pready         = st_reg.ready;
  assign pslverr        = st_reg.slverr;
  assign lad_out        = st_reg.maddr[3:0];
  assign lad_oe         = st_reg.oe;
  assign done_indicator = st_reg.done;
  assign cycle_active   = st_reg.cyc;
  assign is_boot_device = st_reg.boot_id;
  assign auto_start     = st_reg.start;
  assign mux_addr       = st_reg.maddr;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_exit_reset;
    st_reg.in_reset && !dev_reset;
  endsequence

  sequence s_start_req;
    apb_wr && paddr == fpc_pkg::ADDR_CTRL && pwdata[fpc_pkg::CTL_REQ_BIT];
  endsequence

  a_reset_oe_off: assert property (@(posedge mclk) disable iff (srst)
    dev_reset |=> lad_oe == 4'h0)
    else $error("Lines driven during reset.");
  a_reset_no_start: assert property (@(posedge mclk) disable iff (srst)
    dev_reset |=> !auto_start)
    else $error("Automation started in reset.");
  a_refuse_no_start: assert property (@(posedge mclk) disable iff (srst)
    apb_wr && paddr == fpc_pkg::ADDR_CTRL && (hw_block || sw_block) |=> !auto_start)
    else $error("Refused start.");
  a_lock_stable: assert property (@(posedge mclk) disable iff (srst)
    !(apb_wr && paddr == fpc_pkg::ADDR_LOCK) |=> $stable(st_reg.lock))
    else $error("Lock changed.");
  a_done_mirror: assert property (@(posedge mclk) disable iff (srst)
    auto_start |-> !done_indicator)
    else $error("Done high while busy.");
  a_frame_start: assert property (@(posedge mclk) disable iff (srst)
    !st_reg.mux_mode && !dev_reset && !pins.frame_n && st_reg.frame_q |=> cycle_active)
    else $error("No cycle.");
  a_exit_array: assert property (@(posedge mclk) disable iff (srst)
    s_exit_reset |=> st_reg.array_read)
    else $error("Not array read.");
  a_ready_once: assert property (@(posedge mclk) disable iff (srst)
    pready |=> !pready)
    else $error("Ready held.");
  a_mode_sampled: assert property (@(posedge mclk) disable iff (srst)
    s_exit_reset |=> st_reg.mux_mode == $past(pins.port_sel))
    else $error("Port mode not taken at reset exit.");
  a_mode_held: assert property (@(posedge mclk) disable iff (srst)
    !(st_reg.in_reset && !dev_reset) |=> $stable(st_reg.mux_mode))
    else $error("Port mode changed in operation.");
  a_boot_strap: assert property (@(posedge mclk) disable iff (srst)
    s_exit_reset |=> is_boot_device == ($past(pins.strap) == fpc_pkg::BOOT_STRAP))
    else $error("Boot identity not taken from straps.");
  a_top_hw_lock: assert property (@(posedge mclk) disable iff (srst)
    s_start_req ##0 (tsect == fpc_pkg::TOP_SECTOR && !pins.boot_lock) |=> !auto_start)
    else $error("Top sector written while locked.");
  a_other_hw_lock: assert property (@(posedge mclk) disable iff (srst)
    s_start_req ##0 (tsect != fpc_pkg::TOP_SECTOR && !pins.wp) |=> !auto_start)
    else $error("Sector written while protected.");
  a_mux_oe: assert property (@(posedge mclk) disable iff (srst)
    st_reg.mux_mode && pins.rst_n && !pins.init_n |=> lad_oe == 4'hF)
    else $error("Lines not driven with output enable.");
endmodule

// ### include/fpc_pkg.sv
// Shared constants and types for the flash pin control and protection block.
package fpc_pkg;
  localparam int          ADDR_W        = 19;
  localparam int          ROW_W         = 11;
  localparam int          COL_W         = 8;
  localparam int          SECT_N        = 11;
  localparam logic [3:0]  BOOT_STRAP    = 4'h0;
  localparam logic [3:0]  TOP_SECTOR    = 4'hA;
  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_LOCK     = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0008;
  localparam logic [31:0] ADDR_GPI      = 32'h0000_000C;
  localparam logic [31:0] ADDR_REQ      = 32'h0000_0010;
  localparam logic [31:0] ADDR_MUXADDR  = 32'h0000_0014;
  localparam logic [10:0] LOCK_RST      = 11'h000;
  localparam logic [7:0]  BUSY_CYCLES   = 8'h10;
  localparam int          CTL_REQ_BIT   = 0;
  localparam int          CTL_ERASE_BIT = 1;
  localparam int          ST_READY_BIT  = 7;
  localparam int          ST_REFUSE_BIT = 6;
  localparam int          ST_ARRAY_BIT  = 5;
  localparam int          ST_MUX_BIT    = 4;

  typedef enum logic [1:0] {FPC_BUS_IDLE, FPC_BUS_CYCLE} fpc_bus_t;
  typedef enum logic [1:0] {FPC_AUTO_IDLE, FPC_AUTO_BUSY} fpc_auto_t;
endpackage

// ### include/fpc_pin_if.sv
// Synchronised pin bundle passed from the pin stage to the control core.
`timescale 1ns/1ps
interface fpc_pin_if;
  logic       frame_n;
  logic       rst_n;
  logic       init_n;
  logic       boot_lock;
  logic       wp;
  logic [3:0] strap;
  logic [4:0] gpi;
  logic       port_sel;
  logic       rc;
  logic [3:0] lad;
  modport src (output frame_n, rst_n, init_n, boot_lock, wp, strap, gpi, port_sel, rc, lad);
  modport dst (input frame_n, rst_n, init_n, boot_lock, wp, strap, gpi, port_sel, rc, lad);
endinterface

// ### rtl/fpc_sync.sv
// Two-stage synchroniser for every asynchronous pin of the block.
`timescale 1ns/1ps
module fpc_sync
(
  input  wire logic  mclk,
  input  wire logic  srst,
  input  wire logic  frame_start_input_n,
  input  wire logic  rst_pin_n,
  input  wire logic  init_pin_n,
  input  wire logic  boot_sector_lock_input,
  input  wire logic  write_protect_input,
  input  wire logic  [3:0] strap_select_inputs,
  input  wire logic  [4:0] general_purpose_inputs,
  input  wire logic  port_select_input,
  input  wire logic  row_col_strobe,
  input  wire logic  [3:0] lad_in,
  fpc_pin_if.src     pins
);
  typedef struct packed
  {
    logic [19:0] s1;
    logic [19:0] s2;
  } fpc_sync_t;

  fpc_sync_t st_reg;
  fpc_sync_t st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = {frame_start_input_n, rst_pin_n, init_pin_n, boot_sector_lock_input, write_protect_input,
                  strap_select_inputs, general_purpose_inputs, port_select_input, row_col_strobe, lad_in};
    st_next.s2 = st_reg.s1;
    if (srst)
    begin
      // Reset shows a held reset pin, so mode and straps are later taken from live pins.
      st_next.s1 = 20'hA0010;
      st_next.s2 = 20'hA0010;
    end
  end

  always_ff @(posedge mclk)
  begin
    st_reg <= st_next;
  end

  assign {pins.frame_n, pins.rst_n, pins.init_n, pins.boot_lock, pins.wp, pins.strap, pins.gpi,
          pins.port_sel, pins.rc, pins.lad} = st_reg.s2;
endmodule

// ### test/fpc_host_model.sv
// Host chipset model driving frame, reset pins and address/data lines.
`timescale 1ns/1ps
module fpc_host_model
(
  input  wire logic       mclk,
  input  wire logic [3:0] lad_out,
  input  wire logic [3:0] lad_oe,
  output logic            frame_start_input_n,
  output logic            rst_pin_n,
  output logic            init_pin_n,
  output logic      [3:0] lad_in
);
  logic [3:0] pat = 4'h5;
  initial
  begin
    frame_start_input_n = 1'b1;
    rst_pin_n = 1'b1;
    init_pin_n = 1'b1;
  end
  // Lines the device leaves undriven (lad_oe low) show a pattern that moves every cycle.
  always @(posedge mclk) pat <= ~pat + 4'h1;
  assign lad_in = (lad_oe & lad_out) | (~lad_oe & pat);
  // Frame low opens a cycle, or restarts one in progress.
  task automatic frame_low(input int n);
    frame_start_input_n <= 1'b0;
    repeat (n) @(posedge mclk);
    frame_start_input_n <= 1'b1;
  endtask
  task automatic drive_reset(input logic sel, input logic v);
    if (sel)
      init_pin_n <= v;
    else
      rst_pin_n <= v;
  endtask
endmodule

// ### test/fpc_top_tb.sv
// Self-checking bench for the flash pin control and protection block.
`timescale 1ns/1ps
module fpc_top_tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        boot_sector_lock_input = 1'b0;
  logic        write_protect_input = 1'b1;
  logic [3:0]  strap_select_inputs = 4'h0;
  logic [4:0]  general_purpose_inputs = 5'h00;
  logic        port_select_input = 1'b0;
  logic        row_col_strobe = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, frame_start_input_n, rst_pin_n, init_pin_n;
  logic [3:0]  lad_in, lad_out, lad_oe;
  logic        done_indicator, cycle_active, is_boot_device, auto_start;
  logic [18:0] mux_addr;
  int          failures = 0;
  int          n_tests = 0;
  int          n_auto = 0;
  int          a0;
  fpc_top i_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frame_start_input_n, .rst_pin_n, .init_pin_n, .boot_sector_lock_input, .write_protect_input,
    .strap_select_inputs, .general_purpose_inputs, .port_select_input, .row_col_strobe, .lad_in,
    .lad_out, .lad_oe, .done_indicator, .cycle_active, .is_boot_device, .auto_start, .mux_addr);
  fpc_host_model i_host (.mclk, .lad_out, .lad_oe, .frame_start_input_n, .rst_pin_n, .init_pin_n, .lad_in);
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (auto_start === 1'b1) n_auto <= n_auto + 1;
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask
  task automatic req(input logic [31:0] a, input logic [31:0] op, input logic ok);
    a0 = n_auto;
    apb(1'b1, fpc_pkg::ADDR_REQ, a);
    apb(1'b1, fpc_pkg::ADDR_CTRL, op);
    repeat (4) @(posedge mclk);
    chk("auto_start", {31'h0, ok}, 32'(n_auto - a0));
    if (ok)
    begin
      chk("done low", 32'h0, {31'h0, done_indicator});
      repeat (fpc_pkg::BUSY_CYCLES + 8'h04) @(posedge mclk);
      chk("done high", 32'h1, {31'h0, done_indicator});
    end
    else
      rdc("refused", fpc_pkg::ADDR_STATUS, 32'h40, 32'h40);
  endtask
  task automatic dev_reset(input logic sel);
    i_host.drive_reset(sel, 1'b0);
    repeat (6) @(posedge mclk);
    i_host.drive_reset(sel, 1'b1);
    repeat (6) @(posedge mclk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #(40 * 20000);
    failures++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("boot id", 32'h1, {31'h0, is_boot_device});
    rdc("status", fpc_pkg::ADDR_STATUS, 32'hFF, 32'hA8);
    apb(1'b0, 32'h0000_0020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    $display("test reset done");
    strap_select_inputs <= 4'h5;
    general_purpose_inputs <= 5'h13;
    repeat (3) @(posedge mclk);
    rdc("gpi", fpc_pkg::ADDR_GPI, 32'hFFFF_FFFF, 32'h0000_00B3);
    chk("boot id kept", 32'h1, {31'h0, is_boot_device});
    $display("test gpi done");
    i_host.frame_low(2);
    repeat (4) @(posedge mclk);
    chk("cycle", 32'h1, {31'h0, cycle_active});
    i_host.frame_low(1);
    repeat (4) @(posedge mclk);
    rdc("status cycle", fpc_pkg::ADDR_STATUS, 32'h2, 32'h2);
    apb(1'b1, fpc_pkg::ADDR_REQ, 32'h0001_0000);
    i_host.drive_reset(1'b0, 1'b0);
    repeat (4) @(posedge mclk);
    chk("cycle in reset", 32'h0, {31'h0, cycle_active});
    chk("lad_oe", 32'h0, {28'h0, lad_oe});
    a0 = n_auto;
    apb(1'b1, fpc_pkg::ADDR_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    chk("start in reset", 32'h0, 32'(n_auto - a0));
    i_host.drive_reset(1'b0, 1'b1);
    repeat (6) @(posedge mclk);
    rdc("array read", fpc_pkg::ADDR_STATUS, 32'h20, 32'h20);
    i_host.frame_low(2);
    repeat (4) @(posedge mclk);
    i_host.drive_reset(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    chk("cycle in init", 32'h0, {31'h0, cycle_active});
    chk("lad_oe init", 32'h0, {28'h0, lad_oe});
    i_host.drive_reset(1'b1, 1'b1);
    repeat (6) @(posedge mclk);
    $display("test frame done");
    req(32'h0007_0000, 32'h1, 1'b0);
    req(32'h0001_0000, 32'h3, 1'b1);
    boot_sector_lock_input <= 1'b1;
    req(32'h0007_FFFF, 32'h1, 1'b1);
    apb(1'b1, fpc_pkg::ADDR_LOCK, 32'h0000_0400);
    req(32'h0007_0000, 32'h3, 1'b0);
    boot_sector_lock_input <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc("lock kept", fpc_pkg::ADDR_LOCK, 32'hFFFF_FFFF, 32'h0000_0400);
    boot_sector_lock_input <= 1'b1;
    write_protect_input <= 1'b0;
    apb(1'b1, fpc_pkg::ADDR_LOCK, 32'h0000_0000);
    req(32'h0001_0000, 32'h1, 1'b0);
    req(32'h0007_0000, 32'h1, 1'b1);
    write_protect_input <= 1'b1;
    apb(1'b1, fpc_pkg::ADDR_LOCK, 32'h0000_0010);
    req(32'h0001_0000, 32'h3, 1'b0);
    req(32'h0000_0000, 32'h3, 1'b1);
    rdc("lock kept", fpc_pkg::ADDR_LOCK, 32'hFFFF_FFFF, 32'h0000_0010);
    $display("test protect done");
    strap_select_inputs <= 4'h3;
    dev_reset(1'b0);
    chk("not boot", 32'h0, {31'h0, is_boot_device});
    port_select_input <= 1'b1;
    dev_reset(1'b0);
    rdc("mux mode", fpc_pkg::ADDR_STATUS, 32'h10, 32'h10);
    {general_purpose_inputs, write_protect_input, boot_sector_lock_input, strap_select_inputs} <= 11'h5A5;
    repeat (4) @(posedge mclk);
    row_col_strobe <= 1'b0;
    repeat (4) @(posedge mclk);
    {general_purpose_inputs, write_protect_input, boot_sector_lock_input, strap_select_inputs} <= 11'h0C3;
    repeat (4) @(posedge mclk);
    row_col_strobe <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("mux addr", 32'h0006_1DA5, {13'h0, mux_addr});
    rdc("mux reg", fpc_pkg::ADDR_MUXADDR, 32'h0007_FFFF, 32'h0006_1DA5);
    i_host.drive_reset(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    chk("lad_oe mux", 32'hF, {28'h0, lad_oe});
    chk("lad_out mux", 32'h5, {28'h0, lad_out});
    i_host.drive_reset(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    chk("ready", 32'h1, {31'h0, done_indicator});
    $display("test mux done");
    stop_test();
  end
endmodule
